//--- rtl/bss_persist_filter.sv
// consecutive-cycle persistence filter for a fault level
// assumes fault_in synchronous to clk
`timescale 1ns/1ps
module bss_persist_filter
   import bss_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic clr,
   input  wire logic fault_in,
   output logic      fault_out
);
   logic [WF_W-1:0] cnt_ff;
   logic [WF_W-1:0] nxt_cnt;
   logic            fault_ff;
   logic            nxt_fault;

   // count until the fault has stood the full window
   assign nxt_cnt   = (clr || !fault_in) ? '0 :
                      (cnt_ff == WF_LAST) ? cnt_ff : cnt_ff + 2'h1;
   assign nxt_fault = !clr && fault_in && (cnt_ff == WF_LAST);
   assign fault_out = fault_ff;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_ff   <= '0;
         fault_ff <= 1'b0;
      end
      else
      begin
         cnt_ff   <= nxt_cnt;
         fault_ff <= nxt_fault;
      end
   end
endmodule

//--- rtl/bss_precharge_clamp.sv
// hysteretic low-side clamp: on above an upper level, off below a lower level
// assumes comparator flags synchronous to clk
`timescale 1ns/1ps
module bss_precharge_clamp
   import bss_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic arm,
   input  wire logic above_hi,
   input  wire logic below_lo,
   output logic      clamp_on
);
   logic clamp_ff;
   logic nxt_clamp;

   // once set, holds until the low level is crossed, even if arm drops
   assign nxt_clamp = below_lo ? 1'b0 : ((arm && above_hi) ? 1'b1 : clamp_ff);
   assign clamp_on  = clamp_ff | (arm & above_hi & ~below_lo);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         clamp_ff <= 1'b0;
      else
         clamp_ff <= nxt_clamp;
   end
endmodule

//--- rtl/bss_sequencer.sv
// start-up, soft-start and fault sequencer of a buck controller
// assumes comparator flags synchronous to clk (phase clock); rst_b is supply
// power-on reset, so latched overvoltage clears only by power cycling
`timescale 1ns/1ps
module bss_sequencer
   import bss_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic enable_in,
   output logic      enable_out,
   output logic      enable_oe_b,
   output logic      enable_sink_on,
   input  wire logic bias_ok,
   input  wire logic gate_drive_supply_ok,
   input  wire logic pll_locked,
   input  wire logic pwm_in,
   input  wire logic above_target,
   input  wire logic ov_113,
   input  wire logic ov_120,
   input  wire logic below_87,
   input  wire logic uv_below_13,
   input  wire logic window_ok,
   input  wire logic oc_fault,
   input  wire logic ot_hot_150,
   input  wire logic ot_cool_125,
   output logic      high_side_gate_drive,
   output logic      low_side_gate_drive,
   output logic      output_valid_flag,
   output logic [SS_W-1:0] soft_start_ref,
   output logic      soft_start_done,
   output logic      overvoltage_event,
   output logic      undervoltage_event
);
   bss_state_t       state_ff;
   bss_state_t       nxt_state;
   logic [DLY_W-1:0] dly_ff;
   logic [DLY_W-1:0] nxt_dly;
   logic [SS_W-1:0]  ss_ff;
   logic [SS_W-1:0]  nxt_ss;
   logic             pwm_seen_ff;
   logic             nxt_pwm_seen;
   logic             boot_ff;
   logic             nxt_boot;
   logic             ss_done_ff;
   logic             nxt_ss_done;
   logic             ot_ff;
   logic             nxt_ot;
   logic             pre_lock_ff;
   logic             nxt_pre_lock;
   logic             first_ff;
   logic             hs_off_ff;
   logic             nxt_hs_off;
   logic             ls_ov_ff;
   logic             nxt_ls_ov;
   logic             pg_ff;
   logic             nxt_pg;
   logic             uv_ff;
   logic             hs_ff;
   logic             ls_ff;
   logic             nxt_hs;
   logic             nxt_ls;

   wire qualified   = enable_in && bias_ok && gate_drive_supply_ok && pll_locked;
   wire supply_drop = !bias_ok || !gate_drive_supply_ok;
   wire abort       = !qualified || oc_fault || ot_ff;
   wire ov_latched  = (state_ff == BSS_OVLAT);
   wire ov_trip     = ov_120 && ((state_ff == BSS_RAMP) || (state_ff == BSS_RUN));
   wire dly_end     = (dly_ff == DLY_LAST);
   wire ss_end      = (ss_ff == SS_LAST);
   wire switching   = (state_ff == BSS_RAMP) || (state_ff == BSS_RUN);
   // precharge above target blocks the start of switching until it falls
   wire pwm_gate    = switching && pwm_in && !above_target;
   wire win_fault;
   wire ls_clamp;
   wire uv_raw      = ss_done_ff && uv_below_13 && !ov_113 && !oc_fault
                      && !ot_ff && pll_locked;

   // sequencing state; latched overvoltage holds until supply power-on reset
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         BSS_IDLE:  if (qualified && !ot_ff && !pre_lock_ff) nxt_state = BSS_DELAY;
         BSS_DELAY: if (abort) nxt_state = BSS_IDLE;
                    else if (dly_end) nxt_state = BSS_RAMP;
         BSS_RAMP:  if (ov_trip) nxt_state = BSS_OVLAT;
                    else if (abort) nxt_state = BSS_IDLE;
                    else if (ss_end) nxt_state = BSS_RUN;
         BSS_RUN:   if (ov_trip) nxt_state = BSS_OVLAT;
                    else if (abort) nxt_state = BSS_IDLE;
         BSS_OVLAT: nxt_state = BSS_OVLAT;
         default:   nxt_state = BSS_IDLE;
      endcase
   end

   // counters; soft-start cleared the same cycle an abort is seen
   assign nxt_dly = (state_ff == BSS_DELAY && !dly_end) ? dly_ff + 9'h001 : '0;
   assign nxt_ss  = (state_ff == BSS_RAMP && !abort) ?
                    (ss_end ? ss_ff : ss_ff + 12'h001) :
                    ((state_ff == BSS_RUN && !abort) ? SS_LAST : '0);
   assign nxt_ss_done  = (state_ff == BSS_RUN) && !abort;
   assign nxt_pwm_seen = switching && !abort && (pwm_seen_ff || pwm_gate);
   // bootstrap charge only in the cycle the first pulse arrives
   assign nxt_boot     = switching && !abort && pwm_gate && !pwm_seen_ff;
   // over-temperature hysteresis between the two flags
   assign nxt_ot       = ot_hot_150 ? 1'b1 : (ot_cool_125 ? 1'b0 : ot_ff);
   // first cycle after reset samples precharge above 120% for refusal
   assign nxt_pre_lock = pre_lock_ff || (!first_ff && ov_120);
   assign nxt_hs_off   = hs_off_ff || ov_trip || ov_latched;
   assign nxt_ls_ov    = ov_trip ? 1'b1 : (below_87 ? 1'b0 : ls_ov_ff);

   // flag filter: out of window or undervoltage, three cycles in a row
   bss_persist_filter u_win
   (
      .clk       (clk),
      .rst_b     (rst_b),
      .clr       (!ss_done_ff),
      .fault_in  (!window_ok || uv_raw),
      .fault_out (win_fault)
   );

   // hysteretic clamp armed while the shared enable reads low and no overvoltage is latched, held until below_87
   bss_precharge_clamp u_clamp
   (
      .clk      (clk),
      .rst_b    (rst_b),
      .arm      (!enable_in && !ov_latched),
      .above_hi (ov_113),
      .below_lo (below_87),
      .clamp_on (ls_clamp)
   );

   // flag: set after soft-start, dropped on disable or filtered fault
   assign nxt_pg = ss_done_ff && !abort && !ov_latched && !win_fault
                   && (pg_ff || (state_ff == BSS_RUN));

   // gates: off at once on abort, low-side on for clamps or bootstrap
   assign nxt_hs = switching && !abort && !ov_trip && !hs_off_ff
                   && (pwm_seen_ff || pwm_gate) && pwm_in && !boot_ff;
   assign nxt_ls = (ls_ov_ff && !below_87) || ov_trip || ls_clamp
                   || (switching && !abort && !ov_trip && !hs_off_ff
                       && (nxt_boot || (pwm_seen_ff && !pwm_in)));

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_ff    <= BSS_IDLE;
         dly_ff      <= '0;
         ss_ff       <= '0;
         pwm_seen_ff <= 1'b0;
         boot_ff     <= 1'b0;
         ss_done_ff  <= 1'b0;
         ot_ff       <= 1'b0;
         pre_lock_ff <= 1'b0;
         first_ff    <= 1'b0;
      end
      else
      begin
         state_ff    <= nxt_state;
         dly_ff      <= nxt_dly;
         ss_ff       <= nxt_ss;
         pwm_seen_ff <= nxt_pwm_seen;
         boot_ff     <= nxt_boot;
         ss_done_ff  <= nxt_ss_done;
         ot_ff       <= nxt_ot;
         pre_lock_ff <= nxt_pre_lock;
         first_ff    <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hs_off_ff <= 1'b0;
         ls_ov_ff  <= 1'b0;
         pg_ff     <= 1'b0;
         uv_ff     <= 1'b0;
         hs_ff     <= 1'b0;
         ls_ff     <= 1'b0;
      end
      else
      begin
         hs_off_ff <= nxt_hs_off;
         ls_ov_ff  <= nxt_ls_ov;
         pg_ff     <= nxt_pg;
         uv_ff     <= uv_raw;
         hs_ff     <= nxt_hs;
         ls_ff     <= nxt_ls;
      end
   end

   // high side also cut combinationally so turn-off beats one cycle
   assign high_side_gate_drive = hs_ff && !abort && !ov_120 && !hs_off_ff;
   assign low_side_gate_drive  = ls_ff && !(abort && !ls_ov_ff && !ls_clamp
                                            && !ov_trip);
   assign output_valid_flag    = pg_ff;
   assign soft_start_ref       = ss_ff;
   assign soft_start_done      = ss_done_ff;
   assign overvoltage_event    = ov_latched;
   assign undervoltage_event   = uv_ff;
   // open drain: pull low on latched ov, ot, oc or refused precharge
   assign enable_out     = 1'b0;
   assign enable_oe_b    = !(ov_latched || ot_ff || oc_fault || pre_lock_ff);
   assign enable_sink_on = !ss_done_ff && (state_ff != BSS_RAMP);
endmodule

//--- shared/bss_pkg.sv
// constants and state type for the start-up and fault sequencer
// assumes one clock domain, the switching phase clock
package bss_pkg;
   localparam int unsigned DELAY_CYCLES  = 384;   // enable qualified to soft-start
   localparam int unsigned SS_CYCLES     = 2560;  // full soft-start ramp length
   localparam int unsigned WIN_FILTER    = 3;     // power-good fault persistence
   localparam int unsigned GATE_TURNOFF_NS = 100; // longest gate change time
   localparam int unsigned CLK_PERIOD_NS   = 8;
   localparam int unsigned GATE_TURNOFF_CYC =
      (GATE_TURNOFF_NS / CLK_PERIOD_NS) < 1 ? 1 : GATE_TURNOFF_NS / CLK_PERIOD_NS;
   localparam int unsigned DLY_W = 9;
   localparam int unsigned SS_W  = 12;
   localparam int unsigned WF_W  = 2;
   localparam logic [DLY_W-1:0] DLY_LAST = 9'h17f;
   localparam logic [SS_W-1:0]  SS_LAST  = 12'h9ff;
   localparam logic [WF_W-1:0]  WF_LAST  = 2'h2;

   // gray coded along idle -> delay -> ramp -> run
   typedef enum logic [2:0] {
      BSS_IDLE  = 3'b000,
      BSS_DELAY = 3'b001,
      BSS_RAMP  = 3'b011,
      BSS_RUN   = 3'b010,
      BSS_OVLAT = 3'b110
   } bss_state_t;
endpackage

//--- test/bss_peer_model.sv
// paralleled peer module on the shared enable line
// assumes the bench resolves the open-drain wire with a pull-up
`timescale 1ns/1ps
module bss_peer_model
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic fault_req,
   output logic      oe_b
);
   // a peer fault pulls the shared line low, released when it clears
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         oe_b <= 1'b1;
      else
         oe_b <= !fault_req;
endmodule

//--- test/bss_seq_monitor.sv
// checker of the sequencer ports
// assumes one phase clock domain; bound to every bss_sequencer
`timescale 1ns/1ps
module bss_seq_monitor
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic enable_in,
   input wire logic enable_out,
   input wire logic enable_oe_b,
   input wire logic window_ok,
   input wire logic ot_hot_150,
   input wire logic below_87,
   input wire logic high_side_gate_drive,
   input wire logic low_side_gate_drive,
   input wire logic output_valid_flag,
   input wire logic soft_start_done,
   input wire logic overvoltage_event
);
   default clocking mcb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // flag rises only one cycle behind a finished ramp
   property p_flag; $rose(output_valid_flag) |-> $past(soft_start_done); endproperty
   a_flag: assert property (p_flag) else $error("flag before ramp done");
   // a low line drops the flag within two cycles
   property p_dis; !enable_in |-> ##[1:2] !output_valid_flag; endproperty
   a_dis: assert property (p_dis) else $error("flag kept while disabled");
   // one-cycle dip is filtered, a held fault is not
   property p_dip; output_valid_flag && enable_in && !window_ok && $past(window_ok)
      |=> output_valid_flag; endproperty
   a_dip: assert property (p_dip) else $error("flag dropped on dip");
   property p_held; !window_ok [*5] |-> !output_valid_flag; endproperty
   a_held: assert property (p_held) else $error("flag kept on fault");
   // latched trip: line pulled and high side off at once, flag gone next cycle
   property p_ovl; overvoltage_event |-> !enable_oe_b && !high_side_gate_drive
      ##1 !output_valid_flag; endproperty
   a_ovl: assert property (p_ovl) else $error("overvoltage latch leak");
   property p_ovls; $rose(overvoltage_event) && !below_87
      |-> low_side_gate_drive; endproperty
   a_ovls: assert property (p_ovls) else $error("low side off at trip");
   property p_ot; ot_hot_150 ##1 ot_hot_150 |-> !enable_oe_b; endproperty
   a_ot: assert property (p_ot) else $error("hot without pull");
   // pin is only ever pulled low, never driven high
   property p_od; enable_out == 1'b0; endproperty
   a_od: assert property (p_od) else $error("enable driven high");
   c_done: cover property ($rose(soft_start_done));
   c_ov: cover property ($rose(overvoltage_event));
   c_drop: cover property ($fell(output_valid_flag));
endmodule
bind bss_sequencer bss_seq_monitor mon (.clk, .rst_b, .enable_in, .enable_out,
   .enable_oe_b, .window_ok, .ot_hot_150, .below_87, .high_side_gate_drive,
   .low_side_gate_drive, .output_valid_flag, .soft_start_done, .overvoltage_event);

//--- test/tb_top.sv
// bench for the start-up and fault sequencer with one paralleled peer
// assumes a pulled-up enable line; stimulus moves on the rising edge
`timescale 1ns/1ps
module tb_top
   import bss_pkg::*;
;
   logic clk = 1'b0, rst_b = 1'b0, host_en = 1'b0, peer_fault = 1'b0;
   logic bias_ok = 1'b1, gate_drive_supply_ok = 1'b1, pll_locked = 1'b1;
   logic oc_fault = 1'b0, above_target = 1'b0, ov_113 = 1'b0, ov_120 = 1'b0;
   logic below_87 = 1'b0, uv_below_13 = 1'b0, window_ok = 1'b1;
   logic ot_hot_150 = 1'b0, ot_cool_125 = 1'b1;
   logic [1:0] pcnt = 2'h0;
   logic enable_out, enable_oe_b, peer_oe_b, hs, ls, flag, done, ov_ev, uv_ev, sink;
   logic [SS_W-1:0] ss_ref;
   int err_total = 0;
   int n_checks = 0;
   // open-drain line: any party pulling wins over the pull-up
   wire en_pin = host_en & (enable_oe_b | enable_out) & peer_oe_b;
   always #4 clk = ~clk;
   // free-running modulator stand-in; the sequencer must withhold it
   always @(posedge clk) pcnt <= pcnt + 2'h1;
   bss_sequencer uut (.clk, .rst_b, .enable_in(en_pin), .enable_out, .enable_oe_b,
      .enable_sink_on(sink), .bias_ok, .gate_drive_supply_ok, .pll_locked,
      .pwm_in(pcnt[1]), .above_target, .ov_113, .ov_120, .below_87, .uv_below_13,
      .window_ok, .oc_fault, .ot_hot_150, .ot_cool_125, .high_side_gate_drive(hs),
      .low_side_gate_drive(ls), .output_valid_flag(flag), .soft_start_ref(ss_ref),
      .soft_start_done(done), .overvoltage_event(ov_ev), .undervoltage_event(uv_ev));
   bss_peer_model peer (.clk, .rst_b, .fault_req(peer_fault), .oe_b(peer_oe_b));
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      err_total += int'(seen !== exp);
   endtask
   task automatic final_report;
      if (err_total == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // settle past the edge so the sampled outputs are final
   task automatic run(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // quiet levels under supply reset; pre leaves an overcharged output
   task automatic do_reset(logic pre);
      @(posedge clk) rst_b <= 1'b0;
      {host_en, peer_fault, ov_113, below_87, ov_120} <= {4'h0, pre};
      {uv_below_13, window_ok, ot_hot_150, ot_cool_125} <= 4'h5;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
   endtask
   // bounded wait so a stuck ramp still ends the run
   task automatic t_start;
      int n = 0;
      do_reset(1'b0);
      @(posedge clk) host_en <= 1'b1;
      while (done !== 1'b1 && n < 4000)
      begin
         run(1);
         n++;
         if (n == 10)
            chk("delay", {sink, hs, ss_ref}, {2'h2, 12'h000});
      end
      chk("start cycles", 16'(n), 16'(DELAY_CYCLES + SS_CYCLES + 2));
      if (n == 4000)
         final_report;
      chk("flag at done", flag, 1'b0);
      run(1);
      chk("run", {flag, sink, ss_ref}, {2'h2, 12'h9ff});
      run(1);
      chk("gates", hs ^ ls, 1'b1);
   endtask
   task automatic t_win(logic use_uv);
      @(posedge clk) window_ok <= 1'b0;
      repeat (2) @(posedge clk);
      window_ok <= 1'b1;
      run(4);
      chk("flag after dip", flag, 1'b1);
      @(posedge clk) {uv_below_13, window_ok} <= {use_uv, use_uv};
      run(6);
      chk("flag after fault", {flag, uv_ev}, {1'b0, use_uv});
   endtask
   task automatic t_peer;
      @(posedge clk) peer_fault <= 1'b1;
      run(5);
      chk("peer abort", {flag, done, hs, ss_ref}, 15'h0000);
      @(posedge clk) ov_113 <= 1'b1;
      run(3);
      chk("clamp on", {ls, ov_ev}, 2'h2);
      @(posedge clk) {ov_113, below_87} <= 2'h1;
      run(3);
      chk("clamp off", ls, 1'b0);
   endtask
   // hot pulls the line; it stays pulled until the cool flag returns
   task automatic t_ot;
      @(posedge clk) {peer_fault, ot_hot_150, ot_cool_125} <= 3'h2;
      run(3);
      chk("hot pull", enable_oe_b, 1'b0);
      @(posedge clk) ot_hot_150 <= 1'b0;
      run(3);
      chk("between pull", enable_oe_b, 1'b0);
      @(posedge clk) ot_cool_125 <= 1'b1;
      run(3);
      chk("cool release", enable_oe_b, 1'b1);
   endtask
   task automatic t_ov;
      @(posedge clk) ov_120 <= 1'b1;
      run(3);
      chk("ov trip", {ov_ev, hs, ls, enable_oe_b}, 4'ha);
      @(posedge clk) {ov_120, below_87} <= 2'h1;
      run(3);
      chk("ov low side", {ls, flag}, 2'h0);
      @(posedge clk) below_87 <= 1'b0;
      run(3);
      chk("ov held", {ov_ev, ls, enable_oe_b}, 3'h4);
   endtask
   task automatic t_pre;
      @(posedge clk) {ov_120, host_en} <= 2'h1;
      run(500);
      chk("refused", {done, ss_ref, enable_oe_b}, 14'h0000);
   endtask
   initial
   begin
      t_start;
      t_win(1'b0);
      t_start;
      t_win(1'b1);
      t_start;
      t_peer;
      t_ot;
      t_start;
      t_ov;
      do_reset(1'b1);
      t_pre;
      final_report;
   end
endmodule
